/* File: core/wdg_pkg.sv */
package wdg_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] WDG_REG_ADDR        = 8'hd8;
  localparam logic [7:0] WDG_REG_RESET       = 8'hfe;
  localparam logic [7:0] WDG_REARM_VALUE     = 8'hfe;
  localparam int         WDG_ARM_BIT         = 0;
  localparam int         WDG_SWRST_BIT       = 1;
  localparam int         WDG_PERIOD_LO_BIT   = 2;
  localparam int         WDG_PERIOD_HI_BIT   = 7;
  localparam int         WDG_CNT_W           = 7;
  // ==========================================================================
  // Timing
  localparam int         WDG_PRESCALE_CYCLES = 3072;
  localparam int         WDG_MIN_INSTR       = 28;
  localparam int         WDG_INSTR_CYCLES    = 4;
  localparam int         WDG_GUARD_CYCLES    = WDG_MIN_INSTR * WDG_INSTR_CYCLES;
  localparam int         WDG_RST_PULSE       = 4;
  localparam real        WDG_CLK_MHZ         = 50.0;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wdg_bus_t;

  typedef enum logic [1:0] {
    WDG_IDLE,
    WDG_ARMED,
    WDG_FROZEN
  } wdg_state_t;
endpackage

/* File: core/wdg_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module wdg_prescaler #(
  parameter int DIV = 3072
) (
  input  wire logic clock_in,
  input  wire logic srst_in,
  input  wire logic run_in,
  input  wire logic clear_in,
  output logic      tick_out
);
  localparam int CW = $clog2(DIV);

  logic [CW-1:0] cnt_ff;
  logic          tick_ff;
  wire           at_end = (cnt_ff == CW'(DIV - 1));

  // ==========================================================================
  // Divider gated by run_in, one enable pulse per period
  always_ff @(posedge clock_in) begin
    if (srst_in || clear_in) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (run_in) begin
      cnt_ff  <= at_end ? '0 : cnt_ff + 1'b1;
      tick_ff <= at_end;
    end else begin
      tick_ff <= 1'b0;
    end
  end

  assign tick_out = tick_ff;
endmodule
`default_nettype wire

/* File: core/wdg_core.sv */
`timescale 1ns/1ps
`default_nettype none
module wdg_core
  import wdg_pkg::*;
#(
  parameter int PRESCALE = WDG_PRESCALE_CYCLES,
  parameter int GUARD    = WDG_GUARD_CYCLES
) (
  input  wire logic         clock_in,
  input  wire logic         srst_in,
  input  wire wdg_pkg::wdg_bus_t bus_in,
  input  wire logic         hw_activation_in,
  input  wire logic         ext_stop_ctrl_in,
  input  wire logic         stop_req_in,
  input  wire logic         stop_exit_in,
  input  wire logic         nmi_pin_in,
  input  wire logic         nmi_req_in,
  input  wire logic         global_irq_enable_in,
  output logic [7:0]        rdata_out,
  output logic              chip_reset_out,
  output logic              osc_stop_out,
  output logic              wait_mode_out,
  output logic              nmi_service_out,
  output logic              nmi_wake_out
);
  import wdg_pkg::*;

  function automatic logic [5:0] rev6(input logic [5:0] v);
    for (int i = 0; i < 6; i++) begin
      rev6[i] = v[5-i];
    end
  endfunction

  logic [WDG_CNT_W-1:0] cnt_ff;
  logic                 arm_ff;
  logic [7:0]           rdata_ff;
  logic                 rst_ff;
  logic [2:0]           rst_len_ff;
  logic [$clog2(GUARD+1)-1:0] guard_ff;
  logic                 hw_seen_ff;
  logic                 stop_ff;
  logic                 wait_ff;
  logic                 nmi_srv_ff;
  logic                 nmi_wake_ff;
  logic                 tick;

  // ==========================================================================
  // Decode
  wire       wr_hit   = bus_in.wr && (bus_in.addr == WDG_REG_ADDR);
  wire       rd_hit   = bus_in.rd && (bus_in.addr == WDG_REG_ADDR);
  wire       armed    = arm_ff || hw_activation_in;
  wire [6:0] wr_cnt   = {rev6(bus_in.wdata[WDG_PERIOD_HI_BIT:WDG_PERIOD_LO_BIT]),
                         bus_in.wdata[WDG_SWRST_BIT]};
  wire [7:0] rd_val   = {rev6(cnt_ff[6:1]), cnt_ff[0], armed};
  wire       sw_reset = wr_hit && !bus_in.wdata[WDG_SWRST_BIT];
  // Counter bit six sits at index 0 of cnt_ff, the software-reset slot
  wire [6:0] dec_cnt  = {cnt_ff[6:1], cnt_ff[0]};
  wire [6:0] phys     = {dec_cnt[0], rev6(rev6(dec_cnt[6:1]))};
  wire       stop_frz = stop_req_in && ext_stop_ctrl_in && nmi_pin_in;
  wire       stop_wt  = stop_req_in && armed && !stop_frz;
  wire       frozen   = stop_ff;
  wire [6:0] phys_nx  = phys - 7'h01;
  wire       bit6_fall = tick && phys[6] && !phys_nx[6];
  wire       guard_ok = (guard_ff == '0);
  wire       wd_fire  = armed && bit6_fall && guard_ok;
  wire [6:0] cnt_nx   = {phys_nx[5:0], phys_nx[6]};

  wdg_prescaler #(
    .DIV (PRESCALE)
  ) u_pre (
    .clock_in (clock_in),
    .srst_in  (srst_in),
    .run_in   (!frozen),
    .clear_in (wr_hit || rst_ff),
    .tick_out (tick)
  );

  // ==========================================================================
  // Counter and arm bit
  always_ff @(posedge clock_in) begin
    if (srst_in || rst_ff) begin
      cnt_ff <= WDG_REG_RESET[7:1];
      arm_ff <= WDG_REG_RESET[WDG_ARM_BIT];
    end else if (wr_hit) begin
      cnt_ff <= wr_cnt;
      arm_ff <= arm_ff | bus_in.wdata[WDG_ARM_BIT];
    end else if (tick && !frozen) begin
      cnt_ff <= cnt_nx;
    end
  end

  // ==========================================================================
  // Guard window after arming or after reset in hardware mode
  always_ff @(posedge clock_in) begin
    if (srst_in || rst_ff) begin
      guard_ff   <= ($clog2(GUARD+1))'(GUARD);
      hw_seen_ff <= 1'b0;
    end else begin
      hw_seen_ff <= 1'b1;
      if (wr_hit && bus_in.wdata[WDG_ARM_BIT] && !armed) begin
        guard_ff <= ($clog2(GUARD+1))'(GUARD);
      end else if (!guard_ok && (armed || !hw_seen_ff)) begin
        guard_ff <= guard_ff - 1'b1;
      end
    end
  end

  // ==========================================================================
  // Reset pulse, power mode and interrupt wake
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rst_ff      <= 1'b0;
      rst_len_ff  <= '0;
      stop_ff     <= 1'b0;
      wait_ff     <= 1'b0;
      nmi_srv_ff  <= 1'b0;
      nmi_wake_ff <= 1'b0;
      rdata_ff    <= WDG_REG_RESET;
    end else begin
      if (sw_reset || wd_fire) begin
        rst_ff     <= 1'b1;
        rst_len_ff <= 3'(WDG_RST_PULSE - 1);
      end else if (rst_len_ff != '0) begin
        rst_len_ff <= rst_len_ff - 1'b1;
      end else begin
        rst_ff <= 1'b0;
      end
      if (stop_exit_in || rst_ff) begin
        stop_ff <= 1'b0;
        wait_ff <= 1'b0;
      end else if (stop_frz) begin
        stop_ff <= 1'b1;
      end else if (stop_wt) begin
        wait_ff <= 1'b1;
      end
      nmi_srv_ff  <= nmi_req_in;
      nmi_wake_ff <= nmi_req_in && global_irq_enable_in && (stop_ff || wait_ff);
      if (rd_hit) begin
        rdata_ff <= rd_val;
      end
    end
  end

  assign rdata_out       = rdata_ff;
  assign chip_reset_out  = rst_ff;
  assign osc_stop_out    = stop_ff;
  assign wait_mode_out   = wait_ff;
  assign nmi_service_out = nmi_srv_ff;
  assign nmi_wake_out    = nmi_wake_ff;

  // ==========================================================================
  // Checks
  chk_swrst_reset: assert property (@(posedge clock_in) disable iff (srst_in)
    sw_reset |=> chip_reset_out)
    else $error("software reset bit clear did not reset");
  chk_frozen_hold: assert property (@(posedge clock_in) disable iff (srst_in)
    (frozen && !wr_hit && !rst_ff) |=> $stable(cnt_ff))
    else $error("counter moved while frozen");
  chk_hw_arm_read: assert property (@(posedge clock_in) disable iff (srst_in)
    (rd_hit && hw_activation_in) |=> rdata_out[0])
    else $error("arm bit not forced in hardware mode");
  chk_arm_sticky: assert property (@(posedge clock_in) disable iff (srst_in)
    (arm_ff && !rst_ff) |=> arm_ff)
    else $error("arm bit cleared without reset");
  chk_no_fire_disarmed: assert property (@(posedge clock_in) disable iff (srst_in)
    !armed |-> !wd_fire)
    else $error("reset fired while disarmed");
  chk_guard_hold: assert property (@(posedge clock_in) disable iff (srst_in)
    !guard_ok |-> !wd_fire)
    else $error("reset inside guard window");
  chk_reload_map: assert property (@(posedge clock_in) disable iff (srst_in)
    (wr_hit && !rst_ff) |=> (cnt_ff[6:1] == rev6($past(bus_in.wdata[7:2]))))
    else $error("period bits not reversed");
  chk_wake_mask: assert property (@(posedge clock_in) disable iff (srst_in)
    !global_irq_enable_in |=> !nmi_wake_out)
    else $error("masked interrupt woke core");
endmodule
`default_nettype wire

/* File: sim/wdg_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module wdg_host_model (
  input  wire logic             clock_in,
  input  wire logic [7:0]       rdata_in,
  output var wdg_pkg::wdg_bus_t bus_out
);
  import wdg_pkg::*;
  initial bus_out = '0;
  // Software keeps the reset bit set unless it means to reset the chip
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    bus_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_in);
    bus_out <= '0;
  endtask
  task automatic get(output logic [7:0] v);
    @(posedge clock_in);
    bus_out <= '{wr: 1'b0, rd: 1'b1, addr: WDG_REG_ADDR, wdata: 8'h00};
    @(posedge clock_in);
    bus_out <= '0;
    @(posedge clock_in);
    #1 v = rdata_in;
  endtask
endmodule
`default_nettype wire

/* File: sim/wdg_core_test.sv */
`timescale 1ns/1ps
`default_nettype none
module wdg_core_test;
  import wdg_pkg::*;
  logic clock_in = 1'b0, srst_in = 1'b1, hw = 1'b0, ext = 1'b0, stp = 1'b0;
  logic sx = 1'b0, pin = 1'b1, nreq = 1'b0, gie = 1'b0;
  wdg_bus_t   bus;
  logic [7:0] rdata, v, w;
  logic       crst, ostop, wmode, nsrv, nwake;
  int         bad_count = 0, tests_run = 0, cyc = 0, n;
  always #10 clock_in = ~clock_in;
  wdg_host_model wdg_host_model_inst (.clock_in(clock_in), .rdata_in(rdata), .bus_out(bus));
  wdg_core #(.PRESCALE(8), .GUARD(4)) wdg_core_inst (.clock_in(clock_in),
    .srst_in(srst_in), .bus_in(bus), .hw_activation_in(hw), .ext_stop_ctrl_in(ext),
    .stop_req_in(stp), .stop_exit_in(sx), .nmi_pin_in(pin), .nmi_req_in(nreq),
    .global_irq_enable_in(gie), .rdata_out(rdata), .chip_reset_out(crst),
    .osc_stop_out(ostop), .wait_mode_out(wmode), .nmi_service_out(nsrv),
    .nmi_wake_out(nwake));
  // ==========================================
  // Checking helpers
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rchk(input string s, input logic [7:0] e);
    wdg_host_model_inst.get(v);
    chk(s, e, v);
  endtask
  task automatic pulse(input int lo, input int hi);
    #1;
    n = 0;
    while (crst !== 1'b1 && n < hi) begin
      @(posedge clock_in);
      #1 n++;
    end
    chk("reset delay ok", 8'h01, {7'h0, n >= lo && n < hi});
    n = 0;
    while (crst === 1'b1 && n < 20) begin
      @(posedge clock_in);
      #1 n++;
    end
    chk("reset length", 8'(WDG_RST_PULSE), 8'(n));
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset_unmapped();
    wdg_host_model_inst.put(8'hd9, 8'h00);
    rchk("reset value", 8'hfe);
    chk("no reset unmapped", 8'h00, {7'h0, crst});
  endtask
  task automatic t_map_timer();
    wdg_host_model_inst.put(WDG_REG_ADDR, 8'h06);
    rchk("period map a", 8'h06);
    wdg_host_model_inst.put(WDG_REG_ADDR, 8'h82);
    rchk("period map b", 8'h82);
    n = 0;
    repeat (40) begin
      @(posedge clock_in);
      #1 if (crst === 1'b1) n++;
    end
    chk("no reset disarmed", 8'h00, 8'(n));
    rchk("free timer count", 8'h3c);
  endtask
  task automatic t_swreset();
    wdg_host_model_inst.put(WDG_REG_ADDR, 8'hfd);
    pulse(0, 4);
    rchk("after swreset", 8'hfe);
  endtask
  task automatic t_arm();
    wdg_host_model_inst.put(WDG_REG_ADDR, 8'h83);
    wdg_host_model_inst.put(WDG_REG_ADDR, 8'h82);
    rchk("arm sticks", 8'h83);
    pulse(10, 16);
    rchk("disarmed by reset", 8'hfe);
  endtask
  task automatic t_hw_stop();
    @(posedge clock_in);
    hw <= 1'b1;
    ext <= 1'b1;
    srst_in <= 1'b1;
    @(posedge clock_in);
    srst_in <= 1'b0;
    rchk("hw arm", 8'hff);
    wdg_host_model_inst.put(WDG_REG_ADDR, 8'hfe);
    rchk("hw arm write", 8'hff);
    @(posedge clock_in);
    pin <= 1'b1;
    stp <= 1'b1;
    @(posedge clock_in);
    stp <= 1'b0;
    repeat (2) @(posedge clock_in);
    chk("stop entered", 8'h01, {7'h0, ostop});
    wdg_host_model_inst.get(w);
    repeat (30) @(posedge clock_in);
    rchk("count frozen", w);
    @(posedge clock_in);
    sx <= 1'b1;
    @(posedge clock_in);
    sx <= 1'b0;
    pin <= 1'b0;
    stp <= 1'b1;
    @(posedge clock_in);
    stp <= 1'b0;
    repeat (2) @(posedge clock_in);
    chk("stop left", 8'h00, {7'h0, ostop});
    chk("stop as wait", 8'h01, {7'h0, wmode});
    nreq <= 1'b1;
    repeat (3) @(posedge clock_in);
    chk("nmi served", 8'h01, {7'h0, nsrv});
    chk("nmi no wake", 8'h00, {7'h0, nwake});
  endtask
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge clock_in);
    srst_in <= 1'b0;
    t_reset_unmapped();
    t_map_timer();
    t_swreset();
    t_arm();
    t_hw_stop();
    give_verdict();
  end
endmodule
`default_nettype wire
